// [hdl/sslph_link_power.sv]
/*
 Link power handshake: power control register, received-request flags,
 automatic and firmware-driven accept/reject, outbound power requests.
 Assumes the link command path is on core_clk; a sent command is reported
 back by txDone one or more cycles after txCmd is offered.
*/
`timescale 1ns/1ps
module sslph_link_power (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire sslph_pkg::sslph_axi_req_s axiReq,
	output sslph_pkg::sslph_axi_rsp_s axiRsp,
	input wire logic rxGoU1,
	input wire logic rxGoU2,
	input wire logic rxGoU3,
	input wire logic pendingActivity,
	input wire logic lowPowerExited,
	input wire logic [5:0] linkTrainingStateCode,
	output sslph_pkg::sslph_cmd_e txCmd,
	input wire logic txDone,
	output logic enterRequestedState,
	output logic leaveLowPower
);
	import sslph_pkg::*;

	logic [31:0] ctrl;
	logic [31:0] next_ctrl;
	logic [5:0] stateCode;
	logic awHeld, wHeld, bValid, rValid;
	logic next_awHeld, next_wHeld, next_bValid, next_rValid;
	logic [7:0] awAddr;
	logic [7:0] next_awAddr;
	logic [31:0] wData, rData;
	logic [31:0] next_wData, next_rData;
	logic [3:0] wStrb, next_wStrb;
	logic [1:0] bResp, rResp;
	logic [1:0] next_bResp, next_rResp;
	sslph_cmd_e cmd, next_cmd;
	logic wrCtrl;
	logic [31:0] wrVal;
	logic autoAccept, autoReject;

	// Write channel takes address and data in either order
	always_comb begin
		next_awHeld = awHeld;
		next_wHeld = wHeld;
		next_awAddr = awAddr;
		next_wData = wData;
		next_wStrb = wStrb;
		next_bValid = bValid;
		next_bResp = bResp;
		wrCtrl = 1'b0;
		if (axiReq.awvalid && !awHeld && !bValid) begin
			next_awHeld = 1'b1;
			next_awAddr = axiReq.awaddr;
		end
		if (axiReq.wvalid && !wHeld && !bValid) begin
			next_wHeld = 1'b1;
			next_wData = axiReq.wdata;
			next_wStrb = axiReq.wstrb;
		end
		if (awHeld && wHeld) begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bValid = 1'b1;
			wrCtrl = (awAddr[7:2] == CTRL_OFFSET[7:2]);
			next_bResp = (wrCtrl || awAddr[7:2] == STATE_OFFSET[7:2]) ? RESP_OKAY : RESP_SLVERR;
		end
		if (bValid && axiReq.bready)
			next_bValid = 1'b0;
	end

	always_comb begin
		next_rValid = rValid;
		next_rData = rData;
		next_rResp = rResp;
		if (axiReq.arvalid && !rValid) begin
			next_rValid = 1'b1;
			next_rResp = RESP_OKAY;
			if (axiReq.araddr[7:2] == CTRL_OFFSET[7:2])
				next_rData = ctrl;
			else if (axiReq.araddr[7:2] == STATE_OFFSET[7:2])
				next_rData = {26'h0, stateCode};
			else begin
				next_rData = 32'h0;
				next_rResp = RESP_SLVERR;
			end
		end else if (rValid && axiReq.rready)
			next_rValid = 1'b0;
	end

	assign axiRsp.awready = !awHeld && !bValid;
	assign axiRsp.wready = !wHeld && !bValid;
	assign axiRsp.bvalid = bValid;
	assign axiRsp.bresp = bResp;
	assign axiRsp.arready = !rValid;
	assign axiRsp.rvalid = rValid;
	assign axiRsp.rdata = rData;
	assign axiRsp.rresp = rResp;

	// Byte strobes apply to software writes of the control word
	always_comb begin
		wrVal = ctrl;
		for (int i = 0; i < 4; i++)
			if (wStrb[i])
				wrVal[i*8 +: 8] = wData[i*8 +: 8];
	end

	assign autoAccept = ctrl[BIT_U1_AUTO_ACCEPT]
		|| (ctrl[BIT_U1_AUTO_DECIDE] && !pendingActivity);
	assign autoReject = ctrl[BIT_U1_AUTO_REJECT]
		|| (ctrl[BIT_U1_AUTO_DECIDE] && pendingActivity);

	// Later assignments win: hardware events override software writes
	always_comb begin
		logic seenAny;
		logic seenBefore;
		logic setRej, setAcc;
		seenAny = 1'b0;
		seenBefore = |ctrl[BIT_U3_SEEN:BIT_U1_SEEN];
		setRej = 1'b0;
		setAcc = 1'b0;
		next_ctrl = ctrl;
		next_cmd = cmd;
		enterRequestedState = 1'b0;
		if (wrCtrl) begin
			next_ctrl[31:26] = wrVal[31:26];
			// Set-only command bits
			next_ctrl[BIT_LEAVE_LP] = ctrl[BIT_LEAVE_LP] | wrVal[BIT_LEAVE_LP];
			next_ctrl[BIT_SEND_REJECT] = ctrl[BIT_SEND_REJECT] | wrVal[BIT_SEND_REJECT];
			next_ctrl[BIT_SEND_ACCEPT] = ctrl[BIT_SEND_ACCEPT] | wrVal[BIT_SEND_ACCEPT];
			next_ctrl[BIT_SEND_U3:BIT_SEND_U1] = ctrl[BIT_SEND_U3:BIT_SEND_U1]
				| wrVal[BIT_SEND_U3:BIT_SEND_U1];
			// Seen flags clear on write of zero
			next_ctrl[BIT_U3_SEEN:BIT_U1_SEEN] = ctrl[BIT_U3_SEEN:BIT_U1_SEEN]
				& wrVal[BIT_U3_SEEN:BIT_U1_SEEN];
		end
		// Clearing a U2/U3 flag with no command under way is a reject
		if (wrCtrl && !cmd[2] && cmd == SSLPH_CMD_NONE
			&& ((ctrl[BIT_U3_SEEN] && !wrVal[BIT_U3_SEEN])
			|| (ctrl[BIT_U2_SEEN] && !wrVal[BIT_U2_SEEN]))) begin
			next_ctrl[BIT_SEND_REJECT] = 1'b1;
			next_ctrl[BIT_U3_SEEN:BIT_U1_SEEN] = ctrl[BIT_U3_SEEN:BIT_U1_SEEN];
		end
		if (lowPowerExited)
			next_ctrl[BIT_LEAVE_LP] = 1'b0;
		// Received requests: set wins over a clear in the same cycle
		if (rxGoU3) begin
			next_ctrl[BIT_U3_SEEN] = 1'b1;
			seenAny = 1'b1;
		end
		if (rxGoU2) begin
			next_ctrl[BIT_U2_SEEN] = 1'b1;
			seenAny = 1'b1;
		end
		if (rxGoU1) begin
			next_ctrl[BIT_U1_SEEN] = 1'b1;
			seenAny = 1'b1;
			setRej = autoReject;
			setAcc = autoAccept && !autoReject;
		end
		if (rxGoU2 && ctrl[BIT_U2_AUTO_REJECT])
			setRej = 1'b1;
		else if (rxGoU2 && (ctrl[BIT_U2_AUTO_ACCEPT]
			|| (ctrl[BIT_U2_AUTO_DECIDE] && !pendingActivity)))
			setAcc = 1'b1;
		else if (rxGoU2 && ctrl[BIT_U2_AUTO_DECIDE])
			setRej = 1'b1;
		// A request landing while the last answer goes out keeps its own answer
		if (setRej)
			next_ctrl[BIT_SEND_REJECT] = 1'b1;
		if (setAcc)
			next_ctrl[BIT_SEND_ACCEPT] = 1'b1;
		// Launch one command at a time; answers take priority over requests
		if (cmd == SSLPH_CMD_NONE) begin
			if ((ctrl[BIT_SEND_REJECT] || ctrl[BIT_SEND_ACCEPT]) && seenBefore) begin
				next_cmd = ctrl[BIT_SEND_REJECT] ? SSLPH_CMD_REJECT
					: SSLPH_CMD_ACCEPT;
			end else if (ctrl[BIT_SEND_U3]) begin
				next_cmd = SSLPH_CMD_GO_U3;
			end else if (ctrl[BIT_SEND_U2]) begin
				next_cmd = SSLPH_CMD_GO_U2;
			end else if (ctrl[BIT_SEND_U1]) begin
				next_cmd = SSLPH_CMD_GO_U1;
			end
		end else if (txDone) begin
			next_cmd = SSLPH_CMD_NONE;
			case (cmd)
				SSLPH_CMD_ACCEPT, SSLPH_CMD_REJECT: begin
					next_ctrl[BIT_SEND_REJECT] = setRej;
					next_ctrl[BIT_SEND_ACCEPT] = setAcc;
					enterRequestedState = (cmd == SSLPH_CMD_ACCEPT);
					if (!seenAny)
						next_ctrl[BIT_U3_SEEN:BIT_U1_SEEN] = 3'b000;
				end
				SSLPH_CMD_GO_U3: next_ctrl[BIT_SEND_U3] = 1'b0;
				SSLPH_CMD_GO_U2: next_ctrl[BIT_SEND_U2] = 1'b0;
				SSLPH_CMD_GO_U1: next_ctrl[BIT_SEND_U1] = 1'b0;
				default: next_cmd = SSLPH_CMD_NONE;
			endcase
		end
		next_ctrl[25:10] = 16'h0;
		next_ctrl[3] = 1'b0;
	end

	assign txCmd = cmd;
	assign leaveLowPower = ctrl[BIT_LEAVE_LP];

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl <= CTRL_RESET;
			cmd <= SSLPH_CMD_NONE;
			stateCode <= STATE_RESET;
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 8'h00;
			wData <= 32'h0;
			wStrb <= 4'h0;
			bValid <= 1'b0;
			bResp <= RESP_OKAY;
			rValid <= 1'b0;
			rData <= 32'h0;
			rResp <= RESP_OKAY;
		end else begin
			ctrl <= next_ctrl;
			cmd <= next_cmd;
			stateCode <= linkTrainingStateCode;
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			awAddr <= next_awAddr;
			wData <= next_wData;
			wStrb <= next_wStrb;
			bValid <= next_bValid;
			bResp <= next_bResp;
			rValid <= next_rValid;
			rData <= next_rData;
			rResp <= next_rResp;
		end
	end

	property p_ack_clears;
		@(posedge core_clk) disable iff (!rst_n)
		(txDone && (cmd == SSLPH_CMD_ACCEPT || cmd == SSLPH_CMD_REJECT) && !rxGoU1
			&& !rxGoU2 && !rxGoU3)
		|=> (ctrl[BIT_U3_SEEN:BIT_U1_SEEN] == 3'b000) && !ctrl[BIT_SEND_ACCEPT];
	endproperty
	a_ack_clears: assert property (p_ack_clears) else $error("Seen flags not cleared");

	property p_both_reject;
		@(posedge core_clk) disable iff (!rst_n)
		(cmd == SSLPH_CMD_NONE && ctrl[BIT_SEND_REJECT] && |ctrl[BIT_U3_SEEN:BIT_U1_SEEN])
		|=> (cmd == SSLPH_CMD_REJECT);
	endproperty
	a_both_reject: assert property (p_both_reject) else $error("Reject not sent");

	property p_u1_seen;
		@(posedge core_clk) disable iff (!rst_n)
		rxGoU1 |=> ctrl[BIT_U1_SEEN];
	endproperty
	a_u1_seen: assert property (p_u1_seen) else $error("U1 flag missing");

	property p_go_u1_clear;
		@(posedge core_clk) disable iff (!rst_n)
		(cmd == SSLPH_CMD_GO_U1 && txDone) |=> !ctrl[BIT_SEND_U1];
	endproperty
	a_go_u1_clear: assert property (p_go_u1_clear) else $error("Send-U1 stuck");

	property p_leave_lp;
		@(posedge core_clk) disable iff (!rst_n)
		(lowPowerExited && !wrCtrl) |=> !leaveLowPower;
	endproperty
	a_leave_lp: assert property (p_leave_lp) else $error("Leave bit stuck");

	property p_auto_rej;
		@(posedge core_clk) disable iff (!rst_n)
		(rxGoU1 && ctrl[BIT_U1_AUTO_REJECT]) |=> ctrl[BIT_SEND_REJECT];
	endproperty
	a_auto_rej: assert property (p_auto_rej) else $error("No auto reject");

	property p_auto_acc;
		@(posedge core_clk) disable iff (!rst_n)
		(rxGoU1 && ctrl[BIT_U1_AUTO_ACCEPT] && !ctrl[BIT_U1_AUTO_REJECT] && !ctrl[BIT_U1_AUTO_DECIDE])
		|=> ctrl[BIT_SEND_ACCEPT];
	endproperty
	a_auto_acc: assert property (p_auto_acc) else $error("No auto accept");

	property p_state_code;
		@(posedge core_clk) disable iff (!rst_n)
		1'b1 |=> stateCode == $past(linkTrainingStateCode);
	endproperty
	a_state_code: assert property (p_state_code) else $error("State code wrong");

	sequence s_accept_sent;
		txDone && cmd == SSLPH_CMD_ACCEPT && !rxGoU1 && !rxGoU2;
	endsequence
	sequence s_accept_done;
		cmd == SSLPH_CMD_NONE && !ctrl[BIT_SEND_ACCEPT];
	endsequence
	property p_enter_pulse;
		@(posedge core_clk) disable iff (!rst_n)
		s_accept_sent |-> enterRequestedState ##1 s_accept_done;
	endproperty
	a_enter_pulse: assert property (p_enter_pulse) else $error("Accept not taken");

	property p_go_u3_clear;
		@(posedge core_clk) disable iff (!rst_n)
		(cmd == SSLPH_CMD_GO_U3 && txDone) |=> !ctrl[BIT_SEND_U3];
	endproperty
	a_go_u3_clear: assert property (p_go_u3_clear) else $error("Send-U3 stuck");
endmodule

// [hdl/sslph_pkg.sv]
/*
 Package for the link power handshake block: register map, bit positions,
 reset values and carrier structs. Assumes a 32-bit AXI4-Lite register bus.
*/
package sslph_pkg;
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATE_OFFSET = 8'h04;
	localparam int BIT_U2_AUTO_ACCEPT = 31;
	localparam int BIT_U1_AUTO_ACCEPT = 30;
	localparam int BIT_U2_AUTO_REJECT = 29;
	localparam int BIT_U1_AUTO_REJECT = 28;
	localparam int BIT_U2_AUTO_DECIDE = 27;
	localparam int BIT_U1_AUTO_DECIDE = 26;
	localparam int BIT_LEAVE_LP = 9;
	localparam int BIT_SEND_REJECT = 8;
	localparam int BIT_SEND_ACCEPT = 7;
	localparam int BIT_U3_SEEN = 6;
	localparam int BIT_U2_SEEN = 5;
	localparam int BIT_U1_SEEN = 4;
	localparam int BIT_SEND_U3 = 2;
	localparam int BIT_SEND_U2 = 1;
	localparam int BIT_SEND_U1 = 0;
	localparam int STATE_CODE_W = 6;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [STATE_CODE_W-1:0] STATE_RESET = 6'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Link commands the block sends or receives
	typedef enum logic [2:0] {
		SSLPH_CMD_NONE, SSLPH_CMD_GO_U1, SSLPH_CMD_GO_U2, SSLPH_CMD_GO_U3,
		SSLPH_CMD_ACCEPT, SSLPH_CMD_REJECT
	} sslph_cmd_e;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} sslph_axi_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} sslph_axi_rsp_s;
endpackage

// [testbench/sslph_link_partner.sv]
/*
 Far link partner: answers each offered link command with a txDone pulse.
 Assumes the block holds txCmd until it has seen txDone.
*/
`timescale 1ns/1ps
module sslph_link_partner (
	input wire logic core_clk,
	input wire logic stall,
	input wire sslph_pkg::sslph_cmd_e txCmd,
	output logic txDone,
	output sslph_pkg::sslph_cmd_e lastCmd
);
	import sslph_pkg::*;
	initial begin
		txDone = 1'b0;
		lastCmd = SSLPH_CMD_NONE;
	end
	// Stall models a slow transmitter so pending state can be read back
	always @(posedge core_clk) begin
		txDone <= 1'b0;
		if (!stall && !txDone && txCmd != SSLPH_CMD_NONE) begin
			txDone <= 1'b1;
			lastCmd <= txCmd;
		end
	end
endmodule

// [testbench/sslph_link_power_tb_top.sv]
/*
 Bench for the link power handshake: AXI4-Lite tasks and call sequences.
 Assumes the partner model answers commands once its stall is released.
*/
`timescale 1ns/1ps
module sslph_link_power_tb_top;
	import sslph_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	sslph_axi_req_s axiReq = '0;
	sslph_axi_rsp_s axiRsp;
	logic [2:0] rxGo = 3'h0;
	logic pend = 1'b0;
	logic exited = 1'b0;
	logic [5:0] code = 6'h00;
	sslph_cmd_e txCmd;
	sslph_cmd_e lastCmd;
	logic txDone;
	logic enter;
	logic leave;
	logic stall = 1'b0;
	int errorCnt = 0;
	int comparisons = 0;
	int enterCnt = 0;
	logic [31:0] d;
	logic [1:0] r;

	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (enter === 1'b1)
			enterCnt++;
	end

	sslph_link_power i_sslph_link_power (
		.core_clk(core_clk), .rst_n(rst_n), .axiReq(axiReq), .axiRsp(axiRsp),
		.rxGoU1(rxGo[0]), .rxGoU2(rxGo[1]), .rxGoU3(rxGo[2]),
		.pendingActivity(pend), .lowPowerExited(exited),
		.linkTrainingStateCode(code), .txCmd(txCmd), .txDone(txDone),
		.enterRequestedState(enter), .leaveLowPower(leave)
	);
	sslph_link_partner i_sslph_link_partner (
		.core_clk(core_clk), .stall(stall), .txCmd(txCmd), .txDone(txDone), .lastCmd(lastCmd)
	);

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errorCnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Each bus task starts on a fresh edge so no signal is driven twice per step
	task axw(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		axiReq <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: v, wstrb: 4'hf,
			bready: 1'b1, default: '0};
		do begin
			@(posedge core_clk);
			if (axiRsp.awready)
				axiReq.awvalid <= 1'b0;
			if (axiRsp.wready)
				axiReq.wvalid <= 1'b0;
		end while (axiRsp.bvalid !== 1'b1);
		r = axiRsp.bresp;
		axiReq.bready <= 1'b0;
	endtask

	task axr(input logic [7:0] a);
		@(posedge core_clk);
		axiReq <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
		do begin
			@(posedge core_clk);
			if (axiRsp.arready)
				axiReq.arvalid <= 1'b0;
		end while (axiRsp.rvalid !== 1'b1);
		d = axiRsp.rdata;
		r = axiRsp.rresp;
		axiReq.rready <= 1'b0;
	endtask

	task waitTx();
		@(posedge core_clk);
		stall <= 1'b0;
		repeat (2) @(posedge core_clk);
		while (txCmd !== SSLPH_CMD_NONE)
			@(posedge core_clk);
		@(posedge core_clk);
	endtask

	// Request arrives while the partner stalls, so flags can be read first
	task lpCase(input logic [31:0] cfg, input int w, input logic p, input logic [31:0] act,
		input logic [31:0] mid, input sslph_cmd_e cmd, input int ent);
		int e0;
		stall <= 1'b1;
		pend <= p;
		axw(CTRL_OFFSET, cfg);
		@(posedge core_clk);
		rxGo <= 3'h1 << (w - 1);
		@(posedge core_clk);
		rxGo <= 3'h0;
		repeat (3) @(posedge core_clk);
		axr(CTRL_OFFSET);
		chk("ctrl pending", d, cfg | mid);
		e0 = enterCnt;
		axw(CTRL_OFFSET, act);
		waitTx();
		chk("answer", 32'(lastCmd), 32'(cmd));
		chk("enter pulses", enterCnt - e0, ent);
		axr(CTRL_OFFSET);
		chk("ctrl after", d, cfg);
		axw(CTRL_OFFSET, 32'h0);
		$display("Test request case done");
	endtask

	task end_sim();
		$display("Comparisons %0d mismatches %0d", comparisons, errorCnt);
		if (errorCnt == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#100us;
		errorCnt++;
		end_sim();
	end

	initial begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		axr(CTRL_OFFSET);
		chk("ctrl reset", d, CTRL_RESET);
		axr(STATE_OFFSET);
		chk("state reset", d, 32'(STATE_RESET));
		axr(8'h08);
		chk("unmapped rresp", 32'(r), 32'(RESP_SLVERR));
		axw(8'h08, 32'hffff_ffff);
		chk("unmapped bresp", 32'(r), 32'(RESP_SLVERR));
		axr(CTRL_OFFSET);
		chk("unmapped write ignored", d, CTRL_RESET);
		code <= 6'h3f;
		axr(STATE_OFFSET);
		chk("state code", d, 32'h0000_003f);
		$display("Test registers done");
		lpCase(32'h4000_0000, 1, 1'b0, 32'h4000_0070, 32'h90, SSLPH_CMD_ACCEPT, 1);
		lpCase(32'h1000_0000, 1, 1'b0, 32'h1000_0070, 32'h110, SSLPH_CMD_REJECT, 0);
		lpCase(32'h0400_0000, 1, 1'b1, 32'h0400_0070, 32'h110, SSLPH_CMD_REJECT, 0);
		lpCase(32'h0400_0000, 1, 1'b0, 32'h0400_0070, 32'h90, SSLPH_CMD_ACCEPT, 1);
		lpCase(32'h0, 2, 1'b0, 32'hf0, 32'h20, SSLPH_CMD_ACCEPT, 1);
		lpCase(32'h0, 1, 1'b0, 32'h170, 32'h10, SSLPH_CMD_REJECT, 0);
		// U3 is always accepted: an upstream port may not refuse it; the block still sends a reject when the U3 flag is cleared
		lpCase(32'h0, 3, 1'b0, 32'hf0, 32'h40, SSLPH_CMD_ACCEPT, 1);
		lpCase(32'h0, 2, 1'b0, 32'h0, 32'h20, SSLPH_CMD_REJECT, 0);
		lpCase(32'h0, 2, 1'b0, 32'h1f0, 32'h20, SSLPH_CMD_REJECT, 0);
		// No send-U3 here: a device port may not start U3 entry
		for (int b = 0; b < 2; b++) begin
			stall <= 1'b1;
			axw(CTRL_OFFSET, 32'h1 << b);
			axr(CTRL_OFFSET);
			chk("send bit", d, 32'h1 << b);
			chk("offered", 32'(txCmd), b + 1);
			waitTx();
			chk("sent", 32'(lastCmd), b + 1);
			axr(CTRL_OFFSET);
			chk("send cleared", d, 32'h0);
		end
		$display("Test send requests done");
		axw(CTRL_OFFSET, 32'h200);
		chk("leave on", 32'(leave), 32'h1);
		@(posedge core_clk);
		exited <= 1'b1;
		@(posedge core_clk);
		exited <= 1'b0;
		axr(CTRL_OFFSET);
		chk("leave cleared", d, 32'h0);
		chk("leave off", 32'(leave), 32'h0);
		$display("Test leave low power done");
		end_sim();
	end
endmodule
